// >>> rtl/bvi_cpu.sv
// Processor end: grants acknowledges, reads vectors, and steps the handler entry and return.
// Contract
// - Requester drives level 4, own level, seven adds six.
// - Request only with enable and a condition.
// - Request lines held until acknowledged.
// - Acknowledge only above priority, between instructions.
// - Strobe first, chain output 150 ns later.
// - Idle peripheral passes acknowledge down the chain.
// - Four-level requester checks its higher lines.
// - No higher line: block chain on strobe edge.
// - Higher line active: withdraw and pass on.
// - Single-level requester blocks without checking lines.
// - Winner replies and drives its vector.
// - Vector stable within 125 ns of reply.
// - Capture vector, then drop strobe and chain.
// - Peripheral drops reply, releases data in 100 ns.
// - Reply within 10 us of acknowledge.
// - Vector points to handler address and status word.
// - Entry pushes PC and status; return restores.
// - Nearest equal-level requester wins.
// - Position-dependent: own level plus four only.
`timescale 1ns/10ps
`default_nettype none
module bvi_cpu
	import bvi_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	bvi_link_if.cpu          link,
	input  wire logic        instr_done_i,
	input  wire logic        bus_idle_i,
	input  wire logic [15:0] pc_i,
	input  wire logic        mem_ack_i,
	input  wire logic [15:0] mem_rdata_i,
	input  wire logic        return_from_interrupt_i,
	output logic             mem_req_o,
	output logic             mem_write_o,
	output logic [15:0]      mem_addr_o,
	output logic [15:0]      mem_wdata_o,
	output logic [15:0]      new_pc_o,
	output logic             new_pc_valid_o,
	output logic [15:0]      processor_status_word_o,
	output logic [15:0]      vector_o,
	output logic             vector_error_o,
	output logic             timeout_o
);
	typedef enum logic [3:0] {
		BVI_IDLE, BVI_STROBE, BVI_WAIT, BVI_SETTLE, BVI_PUSH_PS, BVI_PUSH_PC,
		BVI_FETCH_PC, BVI_FETCH_PS, BVI_POP_PC, BVI_POP_PS
	} bvi_cstate_t;
	bvi_cstate_t state;
	logic [1:0] reply_sync;
	logic [3:0] lines_sync0;
	logic [3:0] lines_sync;
	logic [CNT_W-1:0] cnt;
	logic [15:0] sp;
	logic [15:0] saved_pc;
	// The request lines come from other clocked logic on the backplane side.
	// They pass two flip-flops before the level encoder reads them.
	// The highest active line sets the level offered against the priority field.
	wire [2:0] req_level = lines_sync[3] ? 3'h7 : lines_sync[2] ? 3'h6 :
		lines_sync[1] ? 3'h5 : lines_sync[0] ? 3'h4 : 3'h0;
	wire [2:0] cur_prio = processor_status_word_o[PRIO_LSB +: 3];
	wire grant_ok = (req_level > cur_prio) & instr_done_i & bus_idle_i;
	assign mem_write_o = (state == BVI_PUSH_PS) | (state == BVI_PUSH_PC);
	assign mem_req_o = (state == BVI_PUSH_PS) | (state == BVI_PUSH_PC) | (state == BVI_FETCH_PC) |
		(state == BVI_FETCH_PS) | (state == BVI_POP_PC) | (state == BVI_POP_PS);
	// Stack pushes write one word below the stack pointer.
	// The pointer moves only when the memory answers, so a stalled word is simply held.
	always_comb begin
		mem_addr_o = sp;
		mem_wdata_o = 16'h0;
		case (state)
			BVI_PUSH_PS: begin
				mem_addr_o = sp - 16'h2;
				mem_wdata_o = processor_status_word_o;
			end
			BVI_PUSH_PC: begin
				mem_addr_o = sp - 16'h2;
				mem_wdata_o = saved_pc;
			end
			BVI_FETCH_PC: mem_addr_o = vector_o;
			BVI_FETCH_PS: mem_addr_o = vector_o + 16'h2;
			BVI_POP_PS: mem_addr_o = sp + 16'h2;
			default: mem_addr_o = sp;
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			reply_sync <= 2'h0;
			lines_sync0 <= 4'h0;
			lines_sync <= 4'h0;
		end else begin
			reply_sync <= {reply_sync[0], link.reply_strobe};
			lines_sync0 <= link.req_proc;
			lines_sync <= lines_sync0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state <= BVI_IDLE;
			cnt <= '0;
			sp <= 16'h1000;
			saved_pc <= 16'h0;
			link.input_strobe <= 1'b0;
			link.ack_chain_out <= 1'b0;
			vector_o <= 16'h0;
			vector_error_o <= 1'b0;
			timeout_o <= 1'b0;
			new_pc_o <= 16'h0;
			new_pc_valid_o <= 1'b0;
			processor_status_word_o <= PS_RESET;
		end else begin
			new_pc_valid_o <= 1'b0;
			timeout_o <= 1'b0;
			case (state)
				BVI_IDLE: begin
					if (return_from_interrupt_i) begin
						state <= BVI_POP_PC;
					end else if (grant_ok) begin
						link.input_strobe <= 1'b1;
						saved_pc <= pc_i;
						cnt <= CNT_W'(STROBE_TO_ACK_CYC - 1);
						state <= BVI_STROBE;
					end
				end
				// The strobe stands alone for the full lead time before the chain output rises.
				BVI_STROBE: begin
					if (cnt == '0) begin
						link.ack_chain_out <= 1'b1;
						cnt <= CNT_W'(REPLY_LIMIT_CYC);
						state <= BVI_WAIT;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				// A chain that never replies is abandoned after the reply limit.
				BVI_WAIT: begin
					if (reply_sync[1]) begin
						cnt <= CNT_W'(VECTOR_SETTLE_CYC);
						state <= BVI_SETTLE;
					end else if (cnt == '0) begin
						link.input_strobe <= 1'b0;
						link.ack_chain_out <= 1'b0;
						timeout_o <= 1'b1;
						state <= BVI_IDLE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				// The vector is sampled only after the settle time has passed.
				BVI_SETTLE: begin
					if (cnt == '0) begin
						vector_o <= link.muxed_addr_data_lines;
						vector_error_o <= (link.muxed_addr_data_lines >= VECTOR_LIMIT);
						link.input_strobe <= 1'b0;
						link.ack_chain_out <= 1'b0;
						state <= BVI_PUSH_PS;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				BVI_PUSH_PS: if (mem_ack_i) begin
					sp <= sp - 16'h2;
					state <= BVI_PUSH_PC;
				end
				BVI_PUSH_PC: if (mem_ack_i) begin
					sp <= sp - 16'h2;
					state <= BVI_FETCH_PC;
				end
				BVI_FETCH_PC: if (mem_ack_i) begin
					new_pc_o <= mem_rdata_i;
					state <= BVI_FETCH_PS;
				end
				BVI_FETCH_PS: if (mem_ack_i) begin
					processor_status_word_o <= mem_rdata_i;
					new_pc_valid_o <= 1'b1;
					state <= BVI_IDLE;
				end
				BVI_POP_PC: if (mem_ack_i) begin
					new_pc_o <= mem_rdata_i;
					state <= BVI_POP_PS;
				end
				BVI_POP_PS: if (mem_ack_i) begin
					processor_status_word_o <= mem_rdata_i;
					sp <= sp + 16'h4;
					new_pc_valid_o <= 1'b1;
					state <= BVI_IDLE;
				end
				default: state <= BVI_IDLE;
			endcase
		end
	end
endmodule // bvi_cpu
`default_nettype wire

// >>> rtl/bvi_pkg.sv
// Package with constants shared by both ends of the vectored interrupt link.
package bvi_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int STROBE_TO_ACK_NS = 150;
	localparam int STROBE_TO_ACK_CYC = (STROBE_TO_ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VECTOR_SETTLE_NS = 125;
	localparam int VECTOR_SETTLE_CYC = VECTOR_SETTLE_NS / CLK_PERIOD_NS;
	localparam int VECTOR_RELEASE_NS = 100;
	localparam int VECTOR_RELEASE_CYC = VECTOR_RELEASE_NS / CLK_PERIOD_NS;
	localparam int REPLY_LIMIT_NS = 10000;
	localparam int REPLY_LIMIT_CYC = REPLY_LIMIT_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 12;
	localparam logic [15:0] VECTOR_LIMIT = 16'h0200;
	localparam logic [2:0] PRIO_RESET = 3'h7;
	localparam logic [15:0] PS_RESET = 16'h00E0;
	localparam int PRIO_LSB = 5;
	localparam logic [1:0] LEVEL_FOUR = 2'h0;
	localparam logic [1:0] LEVEL_FIVE = 2'h1;
	localparam logic [1:0] LEVEL_SIX = 2'h2;
	localparam logic [1:0] LEVEL_SEVEN = 2'h3;
endpackage

// >>> rtl/bvi_link_if.sv
// Interface joining the processor end and one peripheral end of the interrupt link.
`timescale 1ns/10ps
`default_nettype none
interface bvi_link_if;
	logic        input_strobe;
	logic        ack_chain_out;
	logic        ack_chain_in;
	logic        reply_strobe;
	logic [3:0]  req_proc;
	logic [3:0]  req_periph;
	logic [15:0] muxed_addr_data_lines;
	logic        data_oe_n;
	logic        pass_on;

	modport cpu (
		output input_strobe,
		output ack_chain_out,
		input  reply_strobe,
		input  req_proc,
		input  muxed_addr_data_lines
	);
	modport periph (
		input  input_strobe,
		input  ack_chain_in,
		output pass_on,
		output reply_strobe,
		output req_periph,
		input  req_proc,
		output muxed_addr_data_lines,
		output data_oe_n
	);
endinterface
`default_nettype wire

// >>> rtl/bvi_periph.sv
// Peripheral end: requests an interrupt, arbitrates on the chain and supplies its vector.
`timescale 1ns/10ps
`default_nettype none
module bvi_periph
	import bvi_pkg::*;
#(
	parameter logic [1:0] LEVEL = LEVEL_FOUR,
	parameter bit POSITION_DEP = 1'b0,
	parameter bit SINGLE_LEVEL = 1'b0
) (
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	bvi_link_if.periph       link,
	input  wire logic        int_enable_i,
	input  wire logic        condition_i,
	input  wire logic [15:0] vector_i,
	output logic             serviced_o
);
	typedef enum logic [1:0] {BVI_IDLE, BVI_REPLY, BVI_HOLD} bvi_pstate_t;
	bvi_pstate_t state;
	logic [1:0] strobe_sync;
	logic [1:0] ack_sync;
	logic [3:0] lines_sync0;
	logic [3:0] lines_sync;
	logic strobe_d;
	logic pending;
	logic blocked;
	logic passing;
	logic [CNT_W-1:0] rel_cnt;
	wire strobe_rise = strobe_sync[1] & ~strobe_d;
	wire higher_active = (LEVEL == LEVEL_FOUR) ? (lines_sync[1] | lines_sync[2]) :
		(LEVEL == LEVEL_FIVE) ? lines_sync[2] :
		(LEVEL == LEVEL_SIX) ? lines_sync[3] : 1'b0;
	wire contend = pending & (SINGLE_LEVEL | POSITION_DEP | ~higher_active);
	// One assignment drives all four lines, so the request lines have a single driver.
	wire drive_five = pending & (LEVEL == LEVEL_FIVE);
	wire drive_six = pending & ((LEVEL == LEVEL_SIX) |
		((LEVEL == LEVEL_SEVEN) & ~POSITION_DEP));
	wire drive_seven = pending & (LEVEL == LEVEL_SEVEN);
	assign link.req_periph = {drive_seven, drive_six, drive_five, pending};
	assign link.pass_on = ack_sync[1] & passing;
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			strobe_sync <= 2'h0;
			ack_sync <= 2'h0;
			lines_sync0 <= 4'h0;
			lines_sync <= 4'h0;
			strobe_d <= 1'b0;
		end else begin
			strobe_sync <= {strobe_sync[0], link.input_strobe};
			ack_sync <= {ack_sync[0], link.ack_chain_in};
			lines_sync0 <= link.req_proc;
			lines_sync <= lines_sync0;
			strobe_d <= strobe_sync[1];
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			pending <= 1'b0;
			blocked <= 1'b0;
			passing <= 1'b0;
			state <= BVI_IDLE;
			rel_cnt <= '0;
			serviced_o <= 1'b0;
			link.reply_strobe <= 1'b0;
			link.muxed_addr_data_lines <= 16'h0;
			link.data_oe_n <= 1'b1;
		end else begin
			serviced_o <= 1'b0;
			if (int_enable_i & condition_i & ~pending) begin
				pending <= 1'b1;
			end
			if (strobe_rise) begin
				blocked <= contend;
				passing <= ~contend;
			end else if (!strobe_sync[1]) begin
				blocked <= 1'b0;
				passing <= 1'b0;
			end
			case (state)
				BVI_IDLE: begin
					if (blocked & strobe_sync[1] & ack_sync[1]) begin
						link.reply_strobe <= 1'b1;
						link.muxed_addr_data_lines <= vector_i;
						link.data_oe_n <= 1'b0;
						pending <= 1'b0;
						state <= BVI_REPLY;
					end
				end
				BVI_REPLY: begin
					if (!strobe_sync[1]) begin
						link.reply_strobe <= 1'b0;
						rel_cnt <= CNT_W'(VECTOR_RELEASE_CYC - 1);
						state <= BVI_HOLD;
					end
				end
				BVI_HOLD: begin
					if (rel_cnt == '0) begin
						link.data_oe_n <= 1'b1;
						link.muxed_addr_data_lines <= 16'h0;
						serviced_o <= 1'b1;
						state <= BVI_IDLE;
					end else begin
						rel_cnt <= rel_cnt - 1'b1;
					end
				end
				default: state <= BVI_IDLE;
			endcase
		end
	end
endmodule // bvi_periph
`default_nettype wire

// >>> tb/bvi_link_chk.sv
// Checker watching the wire between the processor end and a peripheral end.
`timescale 1ns/10ps
`default_nettype none
module bvi_link_chk
	import bvi_pkg::*;
(
	input wire logic        core_clk_i,
	input wire logic        reset_n_i,
	input wire logic        input_strobe,
	input wire logic        ack_chain_out,
	input wire logic        ack_chain_in,
	input wire logic        reply_strobe,
	input wire logic [3:0]  req_proc,
	input wire logic [3:0]  req_periph,
	input wire logic [15:0] muxed_addr_data_lines,
	input wire logic        data_oe_n,
	input wire logic        pass_on
);
	logic [CNT_W-1:0] wait_cnt;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	// Counts how long a claimed acknowledge has gone without a reply.
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || !ack_chain_in || pass_on || reply_strobe)
			wait_cnt <= '0;
		else
			wait_cnt <= wait_cnt + 1'b1;
	end

	sequence both_s; input_strobe && ack_chain_in; endsequence
	sequence drop_s; $fell(input_strobe); endsequence
	sequence release_s; ##[0:12] data_oe_n; endsequence

	grant_has_req_a: assert property ($rose(input_strobe) |-> req_proc != 4'h0)
		else $error("strobe raised with no request line active");
	ack_after_strobe_a: assert property ($rose(ack_chain_out) |-> $past(input_strobe, 19))
		else $error("acknowledge came less than 150 ns after strobe");
	ack_with_strobe_a: assert property (ack_chain_out |-> input_strobe)
		else $error("acknowledge held without strobe");
	reply_cause_a: assert property ($rose(reply_strobe) |-> both_s)
		else $error("reply without strobe and acknowledge");
	vector_driven_a: assert property (reply_strobe |-> !data_oe_n)
		else $error("reply without vector on the lines");
	vector_steady_a: assert property (reply_strobe && $past(reply_strobe) |->
		$stable(muxed_addr_data_lines))
		else $error("vector moved during reply");
	reply_drops_a: assert property (drop_s |-> ##[0:4] !reply_strobe)
		else $error("reply held after strobe fell");
	data_release_a: assert property ($fell(reply_strobe) |-> release_s)
		else $error("vector not released in time");
	reply_bound_a: assert property (wait_cnt <= REPLY_LIMIT_CYC)
		else $error("reply later than 10 us after acknowledge");
	req_encode_a: assert property (req_periph != 4'h0 |->
		req_periph[0] && (!req_periph[3] || req_periph[2]))
		else $error("request lines wrongly encoded");
endmodule // bvi_link_chk
`default_nettype wire

// >>> tb/test_backplane_vectored_interrupt.sv
// Bench joining the processor end to one peripheral end through the link.
`timescale 1ns/10ps
`default_nettype none
module test_backplane_vectored_interrupt;
	import bvi_pkg::*;
	localparam logic [15:0] VEC = 16'h0100;
	localparam logic [15:0] PC_NOW = 16'h4321;
	logic        core_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        return_from_interrupt = 1'b0, mem_ack = 1'b0, int_en = 1'b0, cond = 1'b1, ready = 1'b1;
	logic [3:0]  tb_req = 4'h0;
	logic        mem_req, mem_write, new_pc_valid, vec_err, tmo, serviced;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, new_pc, psw, vector;
	logic [31:0] wr_q[$];
	int          failures = 0, checks_done = 0, cycles = 0;
	int          strobes = 0, passes = 0, npcs = 0, servs = 0, tmos = 0;

	bvi_link_if link ();
	assign link.ack_chain_in = link.ack_chain_out;
	assign link.req_proc = link.req_periph | tb_req;
	// Memory: return frame at 1000, vector pair at VEC.
	assign mem_rdata = (mem_addr == 16'h1000) ? 16'h3000 : (mem_addr == VEC) ? 16'h2468 :
		(mem_addr == VEC + 16'h0002) ? 16'h0080 : 16'h0000;

	bvi_cpu bvi_cpu_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link(link.cpu),
		.instr_done_i(ready), .bus_idle_i(ready), .pc_i(PC_NOW), .mem_ack_i(mem_ack),
		.mem_rdata_i(mem_rdata), .return_from_interrupt_i(return_from_interrupt), .mem_req_o(mem_req),
		.mem_write_o(mem_write), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
		.new_pc_o(new_pc), .new_pc_valid_o(new_pc_valid), .processor_status_word_o(psw),
		.vector_o(vector), .vector_error_o(vec_err), .timeout_o(tmo));
	bvi_periph #(.LEVEL(LEVEL_FOUR)) bvi_periph_i (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .link(link.periph), .int_enable_i(int_en),
		.condition_i(cond), .vector_i(VEC), .serviced_o(serviced));
	bvi_link_chk bvi_link_chk_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.input_strobe(link.input_strobe), .ack_chain_out(link.ack_chain_out),
		.ack_chain_in(link.ack_chain_in), .reply_strobe(link.reply_strobe),
		.req_proc(link.req_proc), .req_periph(link.req_periph),
		.muxed_addr_data_lines(link.muxed_addr_data_lines), .data_oe_n(link.data_oe_n),
		.pass_on(link.pass_on));

	always #4 core_clk_i = ~core_clk_i;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_for(ref int cnt, input int goal, input int lim);
		int n;
		n = 0;
		while (cnt < goal && n < lim) begin
			@(posedge core_clk_i);
			n++;
		end
		check(cnt, goal);
	endtask

	task automatic close_out();
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Memory answers one word every other cycle; event counters feed the waits.
	always @(posedge core_clk_i) begin
		mem_ack <= mem_req && !mem_ack;
		cycles <= cycles + 1;
		passes <= passes + int'(link.pass_on);
		npcs <= npcs + int'(new_pc_valid);
		servs <= servs + int'(serviced);
		tmos <= tmos + int'(tmo);
		if ($rose(link.input_strobe))
			strobes <= strobes + 1;
		if (mem_req && mem_ack && mem_write)
			wr_q.push_back({mem_addr, mem_wdata});
		if (cycles == 12000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		repeat (16) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		@(posedge core_clk_i);
		check(link.req_periph, 4'h0);
		return_from_interrupt <= 1'b1;
		@(posedge core_clk_i);
		return_from_interrupt <= 1'b0;
		wait_for(npcs, 1, 200);
		check(new_pc, 16'h3000);
		check(psw, 16'h0000);
		tb_req <= 4'h3;
		int_en <= 1'b1;
		wait_for(passes, 1, 200);
		tb_req <= 4'h0;
		wait_for(tmos, 1, 1500);
		wait_for(npcs, 2, 1500);
		wait_for(servs, 1, 200);
		check(vector, VEC);
		check(new_pc, 16'h2468);
		check(psw, 16'h0080);
		check(vec_err, 1'b0);
		check(wr_q.size(), 2);
		check(wr_q[0][15:0], 16'h0000);
		check(wr_q[1][15:0], PC_NOW);
		check(wr_q[0][31:16] - wr_q[1][31:16], 16'h0002);
		cond <= 1'b0;
		@(posedge core_clk_i);
		cond <= 1'b1;
		repeat (300) @(posedge core_clk_i);
		check(strobes, 2);
		close_out();
	end
endmodule // test_backplane_vectored_interrupt
`default_nettype wire
